/* File: verilog/brm_cfg.svh */
/*
  Constants of the buffered control-register bank: address map, field
  positions, reset values and the attribute table of every register.
  Assumes nothing; included by the package and by the design files.

*/
`ifndef BRM_CFG_SVH
`define BRM_CFG_SVH

`define BRM_NREG      24
`define BRM_NSEQ      64
`define BRM_NFUNC     6
`define BRM_ADDR_LAST 16'h0E4F
`define BRM_SEQ_FIRST 16'h0E10
`define BRM_UPD_VAL   8'h01
`define BRM_RST_BYTE  8'h00
`define BRM_RDBK_BUF  0
`define BRM_RDBK_NOWD 3
`define BRM_ACT_BIT   0

// Register indexes into the table below
`define BRM_IX_RDBK  5'h01
`define BRM_IX_UPD   5'h02
`define BRM_IX_ID0   5'h03
`define BRM_IX_ID1   5'h04
`define BRM_IX_FUNC0 5'h09
`define BRM_IX_WD0   5'h0F
`define BRM_IX_WD1   5'h10
`define BRM_IX_MDRV  5'h07
`define BRM_IX_ACT   5'h16
`define BRM_IX_STAT  5'h17

// Addresses, index 23 first
`define BRM_ADDR_TABLE {16'h0D02, 16'h0A00, 16'h0304, 16'h0303, \
  16'h0302, 16'h0301, 16'h0300, 16'h0109, 16'h0108, 16'h0107, \
  16'h0106, 16'h0105, 16'h0104, 16'h0103, 16'h0102, 16'h0101, \
  16'h0100, 16'h000F, 16'h000E, 16'h000D, 16'h000C, 16'h0005, \
  16'h0004, 16'h0000}

// Attributes {live,excl,ro,ac,func swap,stab,wdog,hold,unlock,ref fault},
// index 23 first
`define BRM_FLAG_TABLE {10'h280, 10'h040, 10'h103, 10'h010, \
  10'h004, 10'h002, 10'h001, 10'h008, 10'h008, 10'h020, \
  10'h020, 10'h020, 10'h020, 10'h020, 10'h020, 10'h000, \
  10'h000, 10'h200, 10'h200, 10'h280, 10'h280, 10'h240, \
  10'h000, 10'h300}

`endif

/* File: verilog/brm_pkg.sv */
/*
  Types of the buffered control-register bank.
  Assumes brm_cfg.svh is on the include path.
*/
`include "brm_cfg.svh"

package brm_pkg;

  typedef struct packed {
    logic       live;
    logic       excl;
    logic       ro;
    logic       ac;
    logic [5:0] wcls;
  } brm_flags_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } brm_req_s;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } brm_rsp_s;

  typedef enum logic [2:0] {
    HOLD_IDLE = 3'b001,
    HOLD_WAIT = 3'b010,
    HOLD_ON   = 3'b100
  } brm_hold_e;

endpackage

/* File: verilog/brm_reg_lookup.sv */
/*
  Address decoder: maps a byte address onto a register index and its
  attributes, or onto the storage sequence area.
  Assumes a combinational use inside brm_control_bank.
*/
`timescale 1ns/1ps
`include "brm_cfg.svh"

module brm_reg_lookup
  import brm_pkg::*;
(
  // Address in
  input  wire logic [15:0] addr,
  // Decode out
  output brm_flags_s       flags,
  output logic             hit,
  output logic [4:0]       idx,
  output logic             seq,
  output logic [5:0]       seqIdx
);

  localparam logic [`BRM_NREG-1:0][15:0] ADDRS = `BRM_ADDR_TABLE;
  localparam logic [`BRM_NREG-1:0][9:0]  FLAGS = `BRM_FLAG_TABLE;

  logic [15:0] seqOff;

  assign seqOff = addr - `BRM_SEQ_FIRST;

  always_comb begin
    hit    = 1'b0;
    idx    = 5'h00;
    flags  = '0;
    seq    = 1'b0;
    seqIdx = seqOff[5:0];
    // Anything past the last address never hits
    if (addr >= `BRM_SEQ_FIRST && addr <= `BRM_ADDR_LAST) begin
      hit = 1'b1;
      seq = 1'b1;
    end
    for (int i = 0; i < `BRM_NREG; i++) begin
      if (addr == ADDRS[i]) begin
        hit   = 1'b1;
        idx   = 5'(i);
        flags = brm_flags_s'(FLAGS[i]);
      end
    end
  end

endmodule // brm_reg_lookup

/* File: verilog/brm_control_bank.sv */
/*
  Buffered/active control-register bank with write-detect side effects,
  autoclear bits and serial/EEPROM access arbitration.
  Assumes one byte access per port per cycle, synchronous inputs, and a
  pfdTick enable pulse once per phase-detector cycle.
*/
`timescale 1ns/1ps
`include "brm_cfg.svh"

module brm_control_bank
  import brm_pkg::*;
#(
  parameter logic [7:0] ID_LO = 8'h5A, // Arbitrary identification value
  parameter logic [7:0] ID_HI = 8'hA5  // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Serial port byte access
  input  brm_req_s         spReq,
  output brm_rsp_s         spRsp,
  // EEPROM controller byte access
  input  wire logic        eeBusy,
  input  brm_req_s         eeReq,
  output brm_rsp_s         eeRsp,
  // Functional unit timing and handshakes
  input  wire logic        pfdTick,
  input  wire logic        actionDone,
  // Side effects towards functional units
  output logic             refFaultForce,
  output logic             refTimerRestart,
  output logic             lockUnlockForce,
  output logic             lockRestart,
  output logic             holdover,
  output logic             wdTimerHold,
  output logic             stabTimerHold,
  output logic [5:0]       funcStop,
  output logic             actionReq,
  // Active configuration
  output logic [5:0][7:0]  pinFunc,
  output logic [15:0]      wdPeriod
);

  typedef struct packed {
    logic [`BRM_NREG-1:0][7:0] bufr;
    logic [`BRM_NREG-1:0][7:0] act;
    logic [`BRM_NSEQ-1:0][7:0] seq;
    brm_hold_e                 holdState;
    logic                      holdArm;
    logic                      holdover;
    logic                      refFault;
    logic                      refRestart;
    logic                      unlockForce;
    logic                      lockRestart;
    logic                      wdHold;
    logic                      stabHold;
    logic [5:0]                funcStop;
    brm_rsp_s                  sp;
    brm_rsp_s                  ee;
  } brm_state_s;

  brm_state_s s;
  brm_state_s next_s;

  brm_flags_s spFlags;
  brm_flags_s eeFlags;
  brm_flags_s wFlags;
  logic       spHit;
  logic       eeHit;
  logic [4:0] spIdx;
  logic [4:0] eeIdx;
  logic [4:0] wIdx;
  logic       spSeq;
  logic       eeSeq;
  logic       wSeq;
  logic [5:0] spSeqIdx;
  logic [5:0] eeSeqIdx;
  logic [5:0] wSeqIdx;
  logic [7:0] wData;
  logic       spOkWr;
  logic       spOkRd;
  logic       eeOk;
  logic       wEn;
  logic       update;
  logic       wdOn;
  logic       changed;
  logic [4:0] funcSlot;

  brm_reg_lookup u_sp_lookup (
    .addr   (spReq.addr),
    .flags  (spFlags),
    .hit    (spHit),
    .idx    (spIdx),
    .seq    (spSeq),
    .seqIdx (spSeqIdx)
  );

  brm_reg_lookup u_ee_lookup (
    .addr   (eeReq.addr),
    .flags  (eeFlags),
    .hit    (eeHit),
    .idx    (eeIdx),
    .seq    (eeSeq),
    .seqIdx (eeSeqIdx)
  );

  // Classes narrow access and are ANDed, except ro, which keeps serial reads open while eeBusy
  assign spOkWr = spHit && !spFlags.ro && !eeBusy;
  assign spOkRd = spHit && (spFlags.ro || !eeBusy);
  assign eeOk   = eeHit && !eeFlags.ro && !eeFlags.excl && eeBusy;

  // The busy flag makes the two write sources mutually exclusive
  assign wEn     = eeBusy ? (eeReq.wr && eeOk) : (spReq.wr && spOkWr);
  assign wIdx    = eeBusy ? eeIdx : spIdx;
  assign wSeq    = eeBusy ? eeSeq : spSeq;
  assign wSeqIdx = eeBusy ? eeSeqIdx : spSeqIdx;
  assign wData   = eeBusy ? eeReq.wdata : spReq.wdata;
  assign wFlags  = eeBusy ? eeFlags : spFlags;
  assign update  = wEn && !wSeq && wIdx == `BRM_IX_UPD
                   && wData == `BRM_UPD_VAL;
  assign wdOn    = !s.act[`BRM_IX_RDBK][`BRM_RDBK_NOWD];
  assign changed = wData != s.bufr[wIdx];
  assign funcSlot = wIdx - `BRM_IX_FUNC0;

  // Read value of one location; missing and denied cases are masked outside
  function automatic logic [7:0] rdByte(input logic sq,
                                        input logic [5:0] si,
                                        input logic [4:0] ix);
    logic [7:0] v;
    v = s.act[`BRM_IX_RDBK][`BRM_RDBK_BUF] ? s.bufr[ix] : s.act[ix];
    if (sq) begin
      v = s.seq[si];
    end else if (ix == `BRM_IX_ID0) begin
      v = ID_LO;
    end else if (ix == `BRM_IX_ID1) begin
      v = ID_HI;
    end else if (ix == `BRM_IX_STAT) begin
      v = {2'h0, |s.funcStop, s.stabHold, s.wdHold, s.holdover,
           s.unlockForce, s.refFault};
    end
    return v;
  endfunction

  always_comb begin
    next_s = s;
    next_s.refRestart  = 1'b0;
    next_s.lockRestart = 1'b0;

    // Read answers, one cycle after the request
    next_s.sp.ack   = spReq.rd || spReq.wr;
    next_s.sp.rdata = `BRM_RST_BYTE;
    if (spReq.rd && spOkRd) begin
      next_s.sp.rdata = rdByte(spSeq, spSeqIdx, spIdx);
    end
    next_s.ee.ack   = eeReq.rd || eeReq.wr;
    next_s.ee.rdata = `BRM_RST_BYTE;
    if (eeReq.rd && eeOk) begin
      next_s.ee.rdata = rdByte(eeSeq, eeSeqIdx, eeIdx);
    end

    // Autoclears first so that a new write in the same cycle wins
    if (s.act[`BRM_IX_UPD] != `BRM_RST_BYTE) begin
      next_s.act[`BRM_IX_UPD]  = `BRM_RST_BYTE;
      next_s.bufr[`BRM_IX_UPD] = `BRM_RST_BYTE;
    end
    if (actionDone && s.act[`BRM_IX_ACT][`BRM_ACT_BIT]) begin
      next_s.act[`BRM_IX_ACT][`BRM_ACT_BIT]  = 1'b0;
      next_s.bufr[`BRM_IX_ACT][`BRM_ACT_BIT] = 1'b0;
    end

    // Holdover lasts exactly from one pfdTick to the next
    unique case (s.holdState)
      HOLD_IDLE: next_s.holdState = HOLD_IDLE;
      HOLD_WAIT: next_s.holdState = pfdTick ? HOLD_ON : HOLD_WAIT;
      HOLD_ON:   next_s.holdState = pfdTick ? HOLD_IDLE : HOLD_ON;
      default:   next_s.holdState = HOLD_IDLE;
    endcase

    // Commit: all buffered values except the update register go active together
    if (update) begin
      for (int i = 0; i < `BRM_NREG; i++) begin
        if (i != int'(`BRM_IX_UPD)) begin
          next_s.act[i] = s.bufr[i];
        end
      end
      next_s.refRestart  = s.refFault;
      next_s.refFault    = 1'b0;
      next_s.lockRestart = s.unlockForce;
      next_s.unlockForce = 1'b0;
      next_s.wdHold      = 1'b0;
      next_s.stabHold    = 1'b0;
      next_s.funcStop    = 6'h00;
      // A running holdover pulse is never cut short; the arm waits instead
      if (s.holdArm && s.holdState != HOLD_ON) begin
        next_s.holdArm   = 1'b0;
        next_s.holdState = HOLD_WAIT;
      end
    end
    next_s.holdover = next_s.holdState == HOLD_ON;

    // Writes, after the clears above so a set always wins
    if (wEn) begin
      if (wSeq) begin
        next_s.seq[wSeqIdx] = wData;
      end else begin
        next_s.bufr[wIdx] = wData;
        if (wFlags.live) begin
          next_s.act[wIdx] = wData;
        end
        if (wdOn) begin
          if (wFlags.wcls[0]) begin
            next_s.refFault = 1'b1;
          end
          if (wFlags.wcls[1]) begin
            next_s.unlockForce = 1'b1;
          end
          if (wFlags.wcls[2]) begin
            next_s.holdArm = 1'b1;
          end
          if (wFlags.wcls[3] && changed) begin
            next_s.wdHold = 1'b1;
          end
          if (wFlags.wcls[4] && changed) begin
            next_s.stabHold = 1'b1;
          end
          if (wFlags.wcls[5] && s.act[wIdx] != `BRM_RST_BYTE) begin
            next_s.funcStop[funcSlot[2:0]] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s           <= '0;
      s.holdState <= HOLD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign spRsp           = s.sp;
  assign eeRsp           = s.ee;
  assign refFaultForce   = s.refFault;
  assign refTimerRestart = s.refRestart;
  assign lockUnlockForce = s.unlockForce;
  assign lockRestart     = s.lockRestart;
  assign holdover        = s.holdover;
  assign wdTimerHold     = s.wdHold;
  assign stabTimerHold   = s.stabHold;
  assign funcStop        = s.funcStop;
  assign actionReq       = s.act[`BRM_IX_ACT][`BRM_ACT_BIT];

  generate
    for (genvar g = 0; g < `BRM_NFUNC; g++) begin : g_func
      assign pinFunc[g] = s.act[`BRM_IX_FUNC0 + 5'(g)];
    end
  endgenerate
  assign wdPeriod = {s.act[`BRM_IX_WD1], s.act[`BRM_IX_WD0]};

  property p_commit;
    @(posedge ref_clk) disable iff (sys_rst)
    update |=> s.act[`BRM_IX_WD0] == $past(s.bufr[`BRM_IX_WD0]);
  endproperty
  a_commit: assert property (p_commit)
    else $error("buffered value not committed on update");

  property p_buffered;
    @(posedge ref_clk) disable iff (sys_rst)
    !update |=> s.act[`BRM_IX_MDRV] == $past(s.act[`BRM_IX_MDRV]);
  endproperty
  a_buffered: assert property (p_buffered)
    else $error("buffered register went active without update");

  property p_live;
    @(posedge ref_clk) disable iff (sys_rst)
    wEn && !wSeq && wFlags.live && wIdx != `BRM_IX_UPD
      |=> s.act[$past(wIdx)] == $past(wData);
  endproperty
  a_live: assert property (p_live)
    else $error("live register did not take effect");

  property p_ref_fault;
    @(posedge ref_clk) disable iff (sys_rst)
    wEn && !wSeq && wFlags.wcls[0] && wdOn |=> refFaultForce;
  endproperty
  a_ref_fault: assert property (p_ref_fault)
    else $error("reference not faulted on write");

  property p_wd_off;
    @(posedge ref_clk) disable iff (sys_rst)
    !wdOn && !s.refFault |=> !refFaultForce;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("side effect while write detect disabled");

  property p_hold_one;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(holdover) |-> $past(pfdTick);
  endproperty
  a_hold_one: assert property (p_hold_one)
    else $error("holdover not one PFD cycle");

  property p_hold_stay;
    @(posedge ref_clk) disable iff (sys_rst)
    holdover && !pfdTick |=> holdover;
  endproperty
  a_hold_stay: assert property (p_hold_stay)
    else $error("holdover ended before its PFD cycle");

  property p_hold_bound;
    @(posedge ref_clk) disable iff (sys_rst)
    holdover && pfdTick |=> !holdover;
  endproperty
  a_hold_bound: assert property (p_hold_bound)
    else $error("holdover outlived its PFD cycle");

  property p_busy_deny;
    @(posedge ref_clk) disable iff (sys_rst)
    spReq.rd && eeBusy && !spFlags.ro |=> spRsp.rdata == 8'h00;
  endproperty
  a_busy_deny: assert property (p_busy_deny)
    else $error("serial read of regular register while busy");

  property p_ro_read;
    @(posedge ref_clk) disable iff (sys_rst)
    spReq.rd && spHit && spIdx == `BRM_IX_ID0 |=> spRsp.rdata == ID_LO;
  endproperty
  a_ro_read: assert property (p_ro_read)
    else $error("read-only register not readable");

  property p_ee_excl;
    @(posedge ref_clk) disable iff (sys_rst)
    eeReq.rd && eeFlags.excl |=> eeRsp.rdata == 8'h00;
  endproperty
  a_ee_excl: assert property (p_ee_excl)
    else $error("excluded register reached EEPROM");

  property p_unmapped;
    @(posedge ref_clk) disable iff (sys_rst)
    spReq.rd && !spHit |=> spRsp.ack && spRsp.rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_autoclear;
    @(posedge ref_clk) disable iff (sys_rst)
    s.act[`BRM_IX_UPD] != 8'h00 && !(wEn && wIdx == `BRM_IX_UPD)
      |=> s.act[`BRM_IX_UPD] == 8'h00;
  endproperty
  a_autoclear: assert property (p_autoclear)
    else $error("update register did not autoclear");

endmodule // brm_control_bank

/* File: test/brm_ee_model.sv */
/*
  EEPROM controller model: on a go pulse it claims the bank, makes one
  byte access after a chosen lag, then releases the bank after that lag.
  Assumes the bank answers eeRsp.ack one cycle after a request.
*/
`timescale 1ns/1ps

module brm_ee_model
  import brm_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Command from the bench
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [3:0]  lag,
  output logic             done,
  output logic             ackSeen,
  output logic [7:0]       rdata,
  // Bank side
  output logic             eeBusy,
  output brm_req_s         eeReq,
  input  brm_rsp_s         eeRsp
);
  initial begin
    eeBusy = 1'b0;
    done = 1'b0;
    ackSeen = 1'b0;
    rdata = 8'h00;
    eeReq = '{wr: 1'b0, rd: 1'b0, addr: 16'hFFFF, wdata: 8'hFF};
    forever begin
      @(posedge ref_clk);
      if (go === 1'b1 && sys_rst === 1'b0) begin
        #1;
        eeBusy = 1'b1;
        ackSeen = 1'b0;
        repeat (lag) @(posedge ref_clk);
        #1;
        eeReq = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(posedge ref_clk);
        #1;
        ackSeen = eeRsp.ack;
        rdata = eeRsp.rdata;
        // Released lines show the inverse, never a stale value
        eeReq = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        repeat (lag) @(posedge ref_clk);
        #1;
        eeBusy = 1'b0;
        done = 1'b1;
        @(posedge ref_clk);
        #1;
        done = 1'b0;
      end
    end
  end
endmodule // brm_ee_model

/* File: test/buffered_register_map_control_tb.sv */
/*
  Self-checking bench of the control-register bank: serial port driven
  by tasks, EEPROM side by brm_ee_model.
  Assumes the one-cycle ack timing of both access ports.
*/
`timescale 1ns/1ps

module buffered_register_map_control_tb
  import brm_pkg::*;
;
  localparam logic [7:0] ID_LO = 8'h3C; // Arbitrary identification value
  localparam logic [7:0] ID_HI = 8'hC3; // Arbitrary identification value
  logic            ref_clk, sys_rst, pfdTick, actionDone;
  logic            eeBusy, eeGo, eeWr, eeDone, ackSeen;
  logic [15:0]     eeAddr;
  logic [7:0]      eeData, eeQ;
  logic [3:0]      eeLag;
  brm_req_s        spReq, eeReq;
  brm_rsp_s        spRsp, eeRsp;
  logic            refFaultForce, refTimerRestart, lockUnlockForce;
  logic            lockRestart, holdover, wdTimerHold, stabTimerHold;
  logic            actionReq;
  logic [5:0]      funcStop;
  logic [5:0][7:0] pinFunc;
  logic [15:0]     wdPeriod;
  int              errors, n_tests;

  brm_control_bank #(.ID_LO(ID_LO), .ID_HI(ID_HI)) DUT (.ref_clk,
    .sys_rst, .spReq, .spRsp, .eeBusy, .eeReq, .eeRsp, .pfdTick,
    .actionDone, .refFaultForce, .refTimerRestart, .lockUnlockForce,
    .lockRestart, .holdover, .wdTimerHold, .stabTimerHold, .funcStop,
    .actionReq, .pinFunc, .wdPeriod);

  brm_ee_model EE (.ref_clk, .sys_rst, .go(eeGo), .wr(eeWr),
    .addr(eeAddr), .wdata(eeData), .lag(eeLag), .done(eeDone), .ackSeen,
    .rdata(eeQ), .eeBusy, .eeReq, .eeRsp);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string n, input logic [15:0] s,
                       input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One serial byte access; returns one ns after the answering edge
  task automatic sp_acc(input logic w, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    #1;
    spReq = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    q = spRsp.rdata;
    check("serial ack", spRsp.ack, 16'h1);
    spReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    sp_acc(1'b1, a, d, q);
  endtask

  task automatic rd8(input string n, input logic [15:0] a,
                     input logic [7:0] e);
    logic [7:0] q;
    sp_acc(1'b0, a, 8'h00, q);
    check(n, q, e);
  endtask

  task automatic ee_op(input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic [3:0] l);
    @(posedge ref_clk);
    #1;
    {eeWr, eeAddr, eeData, eeLag, eeGo} = {w, a, d, l, 1'b1};
    @(posedge ref_clk);
    #1;
    eeGo = 1'b0;
    for (int i = 0; i < 40 && eeDone !== 1'b1; i++) begin
      @(posedge ref_clk);
      #2;
    end
    check("ee ack", ackSeen, 16'h1);
  endtask

  task automatic t_map();
    rd8("id low", 16'h000C, ID_LO);
    wr8(16'h000D, 8'h00);
    rd8("id high", 16'h000D, ID_HI);
    wr8(16'h0E50, 8'h77);
    rd8("past map end", 16'h0E50, 8'h00);
    rd8("unmapped", 16'h0006, 8'h00);
    wr8(16'h0E10, 8'hA7);
    wr8(16'h0E4F, 8'h5C);
    rd8("seq first", 16'h0E10, 8'hA7);
    rd8("seq last", 16'h0E4F, 8'h5C);
    wr8(16'h000E, 8'h12);
    rd8("live scratch", 16'h000E, 8'h12);
    $display("map test done");
  endtask

  task automatic t_buffer();
    wr8(16'h0108, 8'h10);
    check("wd hold", wdTimerHold, 16'h1);
    wr8(16'h0109, 8'h20);
    rd8("active low", 16'h0108, 8'h00);
    wr8(16'h0005, 8'h02);
    check("no commit", wdPeriod, 16'h0000);
    wr8(16'h0005, 8'h01);
    check("wd period", wdPeriod, 16'h2010);
    check("wd resumes", wdTimerHold, 16'h0);
    rd8("strobe clear", 16'h0005, 8'h00);
    wr8(16'h0108, 8'h10);
    check("same value", wdTimerHold, 16'h0);
    wr8(16'h0303, 8'h01);
    check("stab hold", stabTimerHold, 16'h1);
    wr8(16'h0005, 8'h01);
    check("stab resumes", stabTimerHold, 16'h0);
    $display("buffer test done");
  endtask

  task automatic t_fault();
    wr8(16'h0300, 8'h01);
    check("ref fault", refFaultForce, 16'h1);
    rd8("status", 16'h0D02, 8'h01);
    wr8(16'h0005, 8'h01);
    check("fault cleared", refFaultForce, 16'h0);
    check("ref restart", refTimerRestart, 16'h1);
    wr8(16'h0301, 8'h01);
    check("unlock", lockUnlockForce, 16'h1);
    wr8(16'h0005, 8'h01);
    check("lock restart", lockRestart, 16'h1);
    wr8(16'h0304, 8'h01);
    check("multi fault", {refFaultForce, lockUnlockForce}, 16'h3);
    wr8(16'h0005, 8'h01);
    check("multi clear", {refFaultForce, lockUnlockForce}, 16'h0);
    $display("fault test done");
  endtask

  task automatic t_hold();
    wr8(16'h0302, 8'h01);
    wr8(16'h0005, 8'h01);
    check("no early hold", holdover, 16'h0);
    @(posedge ref_clk);
    #1;
    pfdTick = 1'b1;
    @(posedge ref_clk);
    #1;
    pfdTick = 1'b0;
    check("hold on", holdover, 16'h1);
    repeat (3) @(posedge ref_clk);
    #1;
    check("hold stays", holdover, 16'h1);
    pfdTick = 1'b1;
    @(posedge ref_clk);
    #1;
    pfdTick = 1'b0;
    check("hold off", holdover, 16'h0);
    $display("holdover test done");
  endtask

  task automatic t_func();
    wr8(16'h0102, 8'h05);
    wr8(16'h0107, 8'h09);
    check("func pending", funcStop, 16'h0);
    wr8(16'h0005, 8'h01);
    check("both at once", {pinFunc[5], pinFunc[0]}, 16'h0905);
    wr8(16'h0102, 8'h07);
    check("func stop", funcStop, 16'h1);
    check("old func", pinFunc[0], 16'h05);
    wr8(16'h0005, 8'h01);
    check("new func", pinFunc[0], 16'h07);
    check("func run", funcStop, 16'h0);
    $display("function test done");
  endtask

  task automatic t_misc();
    wr8(16'h0A00, 8'h01);
    check("ac pending", actionReq, 16'h0);
    wr8(16'h0005, 8'h01);
    check("ac active", actionReq, 16'h1);
    @(posedge ref_clk);
    #1;
    actionDone = 1'b1;
    @(posedge ref_clk);
    #1;
    actionDone = 1'b0;
    check("ac cleared", actionReq, 16'h0);
    wr8(16'h0004, 8'h09);
    wr8(16'h0005, 8'h01);
    wr8(16'h0300, 8'h01);
    check("detect off", refFaultForce, 16'h0);
    wr8(16'h0108, 8'h44);
    check("no wd hold", wdTimerHold, 16'h0);
    rd8("buffered read", 16'h0108, 8'h44);
    wr8(16'h0004, 8'h00);
    wr8(16'h0005, 8'h01);
    check("late commit", wdPeriod, 16'h2044);
    $display("autoclear test done");
  endtask

  task automatic t_eeprom();
    fork
      ee_op(1'b1, 16'h000E, 8'h33, 4'h9);
      begin
        wait (eeBusy === 1'b1);
        rd8("busy regular", 16'h000E, 8'h00);
        wr8(16'h000E, 8'h55);
        rd8("busy ro", 16'h000C, ID_LO);
      end
    join
    rd8("ee wrote", 16'h000E, 8'h33);
    ee_op(1'b0, 16'h000E, 8'h00, 4'h1);
    check("ee regular", eeQ, 16'h33);
    ee_op(1'b0, 16'h000C, 8'h00, 4'h1);
    check("ee ro", eeQ, 16'h00);
    wr8(16'h0000, 8'h24);
    ee_op(1'b1, 16'h0000, 8'h01, 4'h1);
    ee_op(1'b0, 16'h0000, 8'h00, 4'h1);
    check("ee excl", eeQ, 16'h00);
    rd8("serial excl", 16'h0000, 8'h24);
    $display("eeprom test done");
  endtask

  initial begin
    #50000;
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    pfdTick = 1'b0;
    actionDone = 1'b0;
    {eeGo, eeWr, eeAddr, eeData, eeLag} = '0;
    spReq = '{wr: 1'b0, rd: 1'b0, addr: 16'hFFFF, wdata: 8'hFF};
    repeat (10) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    check("reset outputs", {holdover, actionReq, funcStop}, 16'h0);
    t_map();
    t_buffer();
    t_fault();
    t_hold();
    t_func();
    t_misc();
    t_eeprom();
    give_verdict();
  end
endmodule // buffered_register_map_control_tb
